// ### design/fachs_pkg.sv
// fachs_pkg: constants and types for the fragment ack, retry and channel switch block
// assumes a 100 MHz system clock; times are given in clock cycles unless noted
package fachs_pkg;
   // register map (word offsets are byte addresses)
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_SWITCH  = 8'h08;
   localparam logic [7:0] ADDR_CHANNEL = 8'h0C;
   localparam logic [7:0] ADDR_FINAL   = 8'h10;
   // control field positions
   localparam int CTRL_GROUP_LSB  = 0;  // fragments_per_progress_ack, 6 bits
   localparam int CTRL_RETRY_LSB  = 8;  // retry_limit, 3 bits
   localparam int CTRL_DEFER_BIT  = 12; // deferred_final_ack_select
   localparam int CTRL_ACTIVE_BIT = 13; // fragment transaction active
   localparam int CTRL_TOTAL_LSB  = 16; // total fragment count, 5 bits
   localparam logic [2:0] RETRY_LIMIT_RESET = 3'h3;
   localparam logic [5:0] GROUP_RESET       = 6'h00;
   // timing
   localparam int CLK_MHZ              = 100;
   localparam int ACK_WAIT_US          = 10;
   localparam int ACK_WAIT_CYCLES      = ACK_WAIT_US * CLK_MHZ;
   localparam int REVERT_MS            = 100;
   localparam int REVERT_CYCLES        = REVERT_MS * 1000 * CLK_MHZ;
   // channel switch outcome codes
   typedef enum logic [2:0] {
      NTC_SUCCESS        = 3'h0,
      NTC_ACCESS_FAIL    = 3'h1,
      NTC_NO_ACK         = 3'h2,
      NTC_LEGACY         = 3'h3,
      NTC_INVALID_PARAM  = 3'h4
   } fachs_ntc_status_t;
   // originator states, Gray coded along the send, wait, retry path
   typedef enum logic [2:0] {
      ORG_IDLE  = 3'b000,
      ORG_SEND  = 3'b001,
      ORG_WAIT  = 3'b011,
      ORG_RETRY = 3'b010,
      ORG_DONE  = 3'b110
   } fachs_org_t;
   // channel switch states
   typedef enum logic [1:0] {
      SW_IDLE  = 2'b00,
      SW_SEND  = 2'b01,
      SW_WAIT  = 2'b11,
      SW_CHECK = 2'b10
   } fachs_sw_t;
endpackage

// ### design/fachs_core.sv
// fachs_core: originator pacing and retry, recipient final ack, channel switch handshake
// assumes the frame engine around it builds cells and frames and reports link events
// as one-cycle pulses on sys_clk; the radio itself is outside this block
`timescale 1ns/1ps
// Overview of operation
// - pause after each group, await progress ack
// - resend fragments flagged missing, limited retries; a retry limit of zero leaves resends unlimited
// - on timeout resend last fragment, limited
// - retries first in order, then k new
// - ack request yields ack with status element
// - immediate final ack after reassembly, filtering
// - deferred mode: pending ack, status passed upward
// - deferred request triggers final ack with feedback
// - notice only from recipient to originator
// - notice follows final ack, ack requested
// - acknowledged notice moves both to new channel
// - notice never broadcast PAN or address
// - unacknowledged notice keeps current channel
// - revert channel after revert time expires
// - confirm new channel with first fragment
// - switch request carries offset, sequence, transaction
// - address mode idle only, transaction id active only
// - report notice outcome in four of the five codes, never legacy
// - received notice raises indication with fields
// - progress ack mask, groups of eight flags
// - flags lowest first, groups ascending
// - zero group size disables progress acks
// - retry limit zero to seven, default three
module fachs_core
   import fachs_pkg::*;
#(
   parameter int REVERT_COUNT = fachs_pkg::REVERT_CYCLES
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [31:0]      regRdData,
   // originator link events
   input  wire logic        cellSent,
   input  wire logic        progressAckValid,
   input  wire logic [3:0]  progressAckMask,
   input  wire logic [31:0] progressAckFlags,
   output logic             sendCellReq,
   output logic [4:0]       sendCellNum,
   output logic             abortTxn,
   // recipient final acknowledgement
   input  wire logic        finalFragDone,
   input  wire logic        ackRequestFlag,
   input  wire logic        filterDone,
   input  wire logic [31:0] rxFragStatus,
   input  wire logic        deferredAckReq,
   input  wire logic [15:0] deferredFeedback,
   output logic             finalAckReq,
   output logic             finalAckPending,
   output logic             finalAckHasStatus,
   output logic [31:0]      finalAckStatus,
   output logic [15:0]      finalAckFeedback,
   output logic             frameUpInd,
   // channel switch notice
   input  wire logic        noticeTxDone,
   input  wire logic        noticeAcked,
   input  wire logic        noticeAccessFail,
   input  wire logic        noticeRx,
   input  wire logic [31:0] noticeRxFields,
   input  wire logic        linkAlive,
   output logic             noticeTxReq,
   output logic [31:0]      noticeTxFields,
   output logic             noticeTxAckReq,
   output logic             noticeIndication,
   output logic [31:0]      noticeIndFields,
   output logic             channelSwitch,
   output logic [7:0]       activeChannel,
   output logic             confirmFirstFrag
);
   import fachs_pkg::*;

   // configuration held by software
   logic [5:0]  groupSize;
   logic [2:0]  retryLimit;
   logic        deferSelect;
   logic        txnActive;
   logic [4:0]  totalFrags;
   logic [7:0]  newChannel;
   logic [7:0]  seqId;
   logic [15:0] txnId;
   logic        dstBroadcast;
   logic        isRecipient;
   logic        swStart;
   logic [2:0]  ntcStatus;

   // originator state
   fachs_org_t  orgState;
   logic [4:0]  nextFrag;
   logic [5:0]  sentInGroup;
   logic [31:0] retryMask;
   logic [2:0]  timeoutCount;
   logic [2:0]  resendCount;
   logic [4:0]  lastSent;
   logic [15:0] waitTimer;
   logic        cellBusy;

   // switch state
   fachs_sw_t   swState;
   logic [7:0]  prevChannel;
   logic [31:0] revertTimer;
   logic        revertArmed;
   logic        finalAckSeen;

   logic        wrCtrl;
   logic        wrSwitch;
   logic        wrChannel;
   logic        hasRetry;
   logic [4:0]  firstRetry;

   assign wrCtrl    = regWr && (regAddr == ADDR_CTRL);
   assign wrSwitch  = regWr && (regAddr == ADDR_SWITCH);
   assign wrChannel = regWr && (regAddr == ADDR_CHANNEL);

   // lowest pending retry keeps original transmission order
   always_comb begin
      hasRetry   = 1'b0;
      firstRetry = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (retryMask[i]) begin
            hasRetry   = 1'b1;
            firstRetry = 5'(i);
         end
      end
   end

   // control register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         groupSize   <= GROUP_RESET;
         retryLimit  <= RETRY_LIMIT_RESET;
         deferSelect <= 1'b0;
         txnActive   <= 1'b0;
         totalFrags  <= 5'h00;
      end else if (wrCtrl) begin
         groupSize   <= regWrData[CTRL_GROUP_LSB +: 6];
         retryLimit  <= regWrData[CTRL_RETRY_LSB +: 3];
         deferSelect <= regWrData[CTRL_DEFER_BIT];
         txnActive   <= regWrData[CTRL_ACTIVE_BIT];
         totalFrags  <= regWrData[CTRL_TOTAL_LSB +: 5];
      end
   end

   // switch request: channel offset, sequence id, transaction id
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         newChannel   <= 8'h00;
         seqId        <= 8'h00;
         txnId        <= 16'h0000;
         dstBroadcast <= 1'b0;
         isRecipient  <= 1'b0;
         swStart      <= 1'b0;
      end else begin
         swStart <= 1'b0;
         if (wrSwitch) begin
            newChannel <= regWrData[7:0];
            seqId      <= regWrData[15:8];
            // transaction id only counts while a transaction runs
            txnId        <= txnActive ? regWrData[31:16] : 16'h0000;
            swStart      <= 1'b1;
         end
         if (wrChannel) begin
            // broadcast flag is meaningful only for addressed mode when idle
            dstBroadcast <= regWrData[8] && !txnActive;
            isRecipient  <= regWrData[9];
         end
      end
   end

   // originator pacing, retry and timeout
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         orgState     <= ORG_IDLE;
         nextFrag     <= 5'h00;
         sentInGroup  <= 6'h00;
         retryMask    <= 32'h0000_0000;
         timeoutCount <= 3'h0;
         resendCount  <= 3'h0;
         lastSent     <= 5'h00;
         waitTimer    <= 16'h0000;
         cellBusy     <= 1'b0;
         sendCellReq  <= 1'b0;
         sendCellNum  <= 5'h00;
         abortTxn     <= 1'b0;
      end else begin
         sendCellReq <= 1'b0;
         abortTxn    <= 1'b0;
         cellBusy    <= (cellBusy || sendCellReq) && !cellSent;
         unique case (orgState)
            ORG_IDLE: begin
               if (wrCtrl && regWrData[CTRL_ACTIVE_BIT] && !isRecipient) begin
                  orgState    <= ORG_SEND;
                  nextFrag    <= 5'h01; // fragment zero marks abort
                  sentInGroup <= 6'h00;
               end
            end
            ORG_SEND: begin
               if (cellSent) begin
                  sentInGroup <= sentInGroup + 6'h01;
                  // group full: stop and await progress ack
                  if (groupSize != 6'h00 && sentInGroup + 6'h01 >= groupSize) begin
                     orgState  <= ORG_WAIT;
                     waitTimer <= 16'(ACK_WAIT_CYCLES);
                  end else if (!hasRetry && lastSent == totalFrags) begin
                     orgState <= ORG_DONE;
                  end
               end else if (!sendCellReq && !cellBusy) begin
                  sendCellReq <= 1'b1;
                  if (hasRetry) begin
                     // retries precede the k new fragments
                     sendCellNum <= firstRetry;
                     lastSent    <= firstRetry;
                     retryMask[firstRetry] <= 1'b0;
                  end else begin
                     sendCellNum <= nextFrag;
                     lastSent    <= nextFrag;
                     nextFrag    <= nextFrag + 5'h01;
                  end
               end
            end
            ORG_WAIT: begin
               if (progressAckValid) begin
                  timeoutCount <= 3'h0;
                  sentInGroup  <= 6'h00;
                  if (progressAckMask == 4'h0) begin
                     orgState <= ORG_IDLE;
                  end else if (retryLimit != 3'h0 && resendCount >= retryLimit
                               && progressAckFlags != 32'hFFFF_FFFF) begin
                     abortTxn <= 1'b1;
                     orgState <= ORG_IDLE;
                  end else begin
                     // flags below the next new fragment, per present group
                     for (int g = 0; g < 4; g++) begin
                        for (int b = 0; b < 8; b++) begin
                           if (progressAckMask[g] && !progressAckFlags[g*8+b]
                               && (g*8+b) > 0 && 5'(g*8+b) < nextFrag) begin
                              retryMask[g*8+b] <= 1'b1;
                           end
                        end
                     end
                     if (progressAckFlags != 32'hFFFF_FFFF) begin
                        resendCount <= resendCount + 3'h1;
                     end
                     orgState <= (lastSent == totalFrags && progressAckFlags == 32'hFFFF_FFFF)
                                 ? ORG_DONE : ORG_SEND;
                  end
               end else if (waitTimer == 16'h0001) begin
                  if (timeoutCount >= retryLimit) begin
                     abortTxn <= 1'b1;
                     orgState <= ORG_IDLE;
                  end else begin
                     orgState <= ORG_RETRY;
                  end
               end else begin
                  waitTimer <= waitTimer - 16'h0001;
               end
            end
            ORG_RETRY: begin
               // resend the last fragment, then wait again
               if (cellSent) begin
                  timeoutCount <= timeoutCount + 3'h1;
                  waitTimer    <= 16'(ACK_WAIT_CYCLES);
                  orgState     <= ORG_WAIT;
               end else if (!sendCellReq && !cellBusy) begin
                  sendCellReq <= 1'b1;
                  sendCellNum <= lastSent;
               end
            end
            ORG_DONE: begin
               if (!txnActive) begin
                  orgState <= ORG_IDLE;
               end
            end
            default: orgState <= ORG_IDLE;
         endcase
      end
   end

   // recipient final acknowledgement
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         finalAckReq       <= 1'b0;
         finalAckPending   <= 1'b0;
         finalAckHasStatus <= 1'b0;
         finalAckStatus    <= 32'h0000_0000;
         finalAckFeedback  <= 16'h0000;
         frameUpInd        <= 1'b0;
         finalAckSeen      <= 1'b0;
      end else begin
         finalAckReq  <= 1'b0;
         frameUpInd   <= 1'b0;
         finalAckSeen <= 1'b0;
         if (finalFragDone && ackRequestFlag && !deferSelect && filterDone) begin
            // wait for reassembly and filtering before answering
            finalAckReq       <= 1'b1;
            finalAckPending   <= 1'b0;
            finalAckHasStatus <= 1'b1;
            finalAckStatus    <= rxFragStatus;
            finalAckSeen      <= 1'b1;
         end else if (finalFragDone && ackRequestFlag && deferSelect) begin
            finalAckReq       <= 1'b1;
            finalAckPending   <= 1'b1;
            finalAckHasStatus <= 1'b0;
            finalAckStatus    <= rxFragStatus;
            frameUpInd        <= 1'b1;
         end else if (deferredAckReq && deferSelect) begin
            finalAckReq       <= 1'b1;
            finalAckPending   <= 1'b0;
            finalAckHasStatus <= 1'b1;
            finalAckFeedback  <= deferredFeedback;
            finalAckSeen      <= 1'b1;
         end
      end
   end

   // channel switch notice handshake and revert
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         swState          <= SW_IDLE;
         noticeTxReq      <= 1'b0;
         noticeTxFields   <= 32'h0000_0000;
         noticeTxAckReq   <= 1'b0;
         ntcStatus        <= NTC_SUCCESS;
         channelSwitch    <= 1'b0;
         activeChannel    <= 8'h00;
         prevChannel      <= 8'h00;
         revertTimer      <= 32'h0000_0000;
         revertArmed      <= 1'b0;
         confirmFirstFrag <= 1'b0;
         noticeIndication <= 1'b0;
         noticeIndFields  <= 32'h0000_0000;
      end else begin
         noticeTxReq      <= 1'b0;
         channelSwitch    <= 1'b0;
         noticeIndication <= 1'b0;
         confirmFirstFrag <= 1'b0;
         if (noticeRx) begin
            noticeIndication <= 1'b1;
            noticeIndFields  <= noticeRxFields;
            prevChannel      <= activeChannel;
            activeChannel    <= noticeRxFields[7:0];
            channelSwitch    <= 1'b1;
            revertArmed      <= 1'b1;
            revertTimer      <= REVERT_COUNT;
            confirmFirstFrag <= !isRecipient;
         end
         unique case (swState)
            SW_IDLE: begin
               if (swStart) begin
                  // only a recipient, never to broadcast
                  if (!isRecipient || dstBroadcast) begin
                     ntcStatus <= NTC_INVALID_PARAM;
                  end else begin
                     swState <= SW_SEND;
                  end
               end
            end
            SW_SEND: begin
               // the notice waits for the aggregated final ack, or goes at once when no transaction is active
               if (finalAckSeen || !txnActive) begin
                  noticeTxReq    <= 1'b1;
                  noticeTxFields <= {txnId, seqId, newChannel};
                  noticeTxAckReq <= 1'b1;
                  swState        <= SW_WAIT;
               end
            end
            SW_WAIT: begin
               if (noticeTxDone) begin
                  swState <= SW_CHECK;
                  if (noticeAccessFail) begin
                     ntcStatus <= NTC_ACCESS_FAIL;
                  end else if (!noticeAcked) begin
                     ntcStatus <= NTC_NO_ACK;
                  end else begin
                     ntcStatus     <= NTC_SUCCESS;
                     prevChannel   <= activeChannel;
                     activeChannel <= newChannel;
                     channelSwitch <= 1'b1;
                     revertArmed   <= 1'b1;
                     revertTimer   <= REVERT_COUNT;
                  end
               end
            end
            SW_CHECK: swState <= SW_IDLE;
         endcase
         if (revertArmed && !noticeRx && !(swState == SW_WAIT && noticeTxDone)) begin
            if (linkAlive) begin
               revertArmed <= 1'b0;
            end else if (revertTimer == 32'h0000_0001) begin
               activeChannel <= prevChannel;
               channelSwitch <= 1'b1;
               revertArmed   <= 1'b0;
            end else begin
               revertTimer <= revertTimer - 32'h0000_0001;
            end
         end
      end
   end

   // read port: data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regRdData <= 32'h0000_0000;
      end else if (regRd) begin
         unique case (regAddr)
            ADDR_CTRL:    regRdData <= {11'h000, totalFrags, 2'b00, txnActive, deferSelect,
                                        1'b0, retryLimit, 2'b00, groupSize};
            ADDR_STATUS:  regRdData <= {9'h000, ntcStatus, swState, 2'b00,
                                        timeoutCount, resendCount, orgState,
                                        nextFrag, 1'b0, revertArmed};
            ADDR_SWITCH:  regRdData <= {txnId, seqId, newChannel};
            ADDR_CHANNEL: regRdData <= {prevChannel, 6'h00, isRecipient, dstBroadcast,
                                        8'h00, activeChannel};
            ADDR_FINAL:   regRdData <= finalAckStatus;
            default:      regRdData <= 32'h0000_0000;
         endcase
      end else begin
         regRdData <= 32'h0000_0000;
      end
   end
endmodule

// ### test/fachs_core_properties.sv
// fachs_core_properties: port-level checker for fachs_core
// assumes it is bound onto fachs_core and sees only its ports
`timescale 1ns/1ps
module fachs_core_checker
   import fachs_pkg::*;
#(
   parameter int REVERT_COUNT = fachs_pkg::REVERT_CYCLES
) (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst,
   // watched ports
   input wire logic        regRd,
   input wire logic [31:0] regRdData,
   input wire logic        finalFragDone,
   input wire logic        filterDone,
   input wire logic        ackRequestFlag,
   input wire logic        finalAckReq,
   input wire logic        frameUpInd,
   input wire logic        finalAckPending,
   input wire logic        deferredAckReq,
   input wire logic [15:0] deferredFeedback,
   input wire logic [15:0] finalAckFeedback,
   input wire logic        noticeRx,
   input wire logic [31:0] noticeRxFields,
   input wire logic        noticeIndication,
   input wire logic [31:0] noticeIndFields,
   input wire logic        noticeTxDone,
   input wire logic        noticeAcked,
   input wire logic        noticeAccessFail,
   input wire logic        noticeTxReq,
   input wire logic        noticeTxAckReq,
   input wire logic        channelSwitch,
   input wire logic [7:0]  activeChannel,
   input wire logic        progressAckValid,
   input wire logic [3:0]  progressAckMask,
   input wire logic        sendCellReq
);
   // one clock domain, one default clock and reset
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_rd_idle; !$past(regRd) |-> regRdData == 32'h0000_0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
   property p_final; finalFragDone && filterDone && ackRequestFlag |=> finalAckReq || frameUpInd;
   endproperty
   a_final: assert property (p_final) else $error("no final ack response");
   property p_defer; deferredAckReq && finalAckPending |=>
      finalAckReq && finalAckFeedback == $past(deferredFeedback); endproperty
   a_defer: assert property (p_defer) else $error("no deferred ack");
   property p_ind; noticeRx |=> noticeIndication && noticeIndFields == $past(noticeRxFields);
   endproperty
   a_ind: assert property (p_ind) else $error("notice indication wrong");
   property p_noack; noticeTxDone && !noticeAcked && !noticeAccessFail |=>
      (!channelSwitch && $stable(activeChannel)) [*3]; endproperty
   a_noack: assert property (p_noack) else $error("switch without ack");
   property p_acked; noticeTxDone && noticeAcked && !noticeAccessFail |-> ##[1:3] channelSwitch;
   endproperty
   a_acked: assert property (p_acked) else $error("no switch on ack");
   property p_nreq; noticeTxReq |=> noticeTxAckReq; endproperty
   a_nreq: assert property (p_nreq) else $error("notice without ack request");
   property p_abort; progressAckValid && progressAckMask == 4'h0 |=> !sendCellReq [*8];
   endproperty
   a_abort: assert property (p_abort) else $error("cells after aborting ack");
endmodule
bind fachs_core fachs_core_checker #(.REVERT_COUNT(REVERT_COUNT)) i_fachs_core_checker (.*);

// ### test/fachs_peer_model.sv
// fachs_peer_model: far node as seen by the block, airtime and notice acknowledgement
// assumes one sys_clk; the bench sets airtime and notice ack
`timescale 1ns/1ps
module fachs_peer_model (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // requests and scenario controls
   input  wire logic sendCellReq,
   input  wire logic noticeTxReq,
   input  wire logic slowPeer,
   input  wire logic ackNotice,
   // link events
   output logic      cellSent,
   output logic      noticeTxDone,
   output logic      noticeAcked,
   output logic      noticeAccessFail
);
   logic [2:0] cellWait;
   logic [1:0] noticeWait;
   // a cell leaves after its airtime; slow airtime stresses the pacing
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cellWait <= 3'h0;
         cellSent <= 1'b0;
      end else begin
         cellSent <= (cellWait == 3'h1);
         cellWait <= sendCellReq ? (slowPeer ? 3'h5 : 3'h1) : cellWait - (cellWait != 3'h0);
      end
   end
   // status levels toggle outside the done pulse so a stale sample shows up
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         noticeWait <= 2'h0;
         noticeTxDone <= 1'b0;
         noticeAcked <= 1'b0;
         noticeAccessFail <= 1'b0;
      end else begin
         noticeWait <= noticeTxReq ? 2'h3 : noticeWait - (noticeWait != 2'h0);
         noticeTxDone <= (noticeWait == 2'h1);
         noticeAcked <= (noticeWait == 2'h1) ? ackNotice : ~noticeAcked;
         noticeAccessFail <= (noticeWait == 2'h1) ? 1'b0 : ~noticeAccessFail;
      end
   end
endmodule

// ### test/testbench.sv
// testbench: register, originator, final ack and channel switch sequences
// assumes fachs_core with a short revert count and the peer model
`timescale 1ns/1ps
module testbench;
   import fachs_pkg::*;
   localparam int REV = 50;
   logic sys_clk, rst, regWr, regRd, cellSent, progressAckValid, sendCellReq, abortTxn;
   logic finalFragDone, ackRequestFlag, filterDone, deferredAckReq, finalAckReq;
   logic finalAckPending, finalAckHasStatus, frameUpInd, noticeTxDone, noticeAcked;
   logic noticeAccessFail, noticeRx, linkAlive, noticeTxReq, noticeTxAckReq;
   logic noticeIndication, channelSwitch, confirmFirstFrag, slowPeer, ackNotice;
   logic [3:0]  progressAckMask;
   logic [4:0]  sendCellNum;
   logic [7:0]  regAddr, activeChannel;
   logic [15:0] deferredFeedback, finalAckFeedback;
   logic [19:0] cellLog;
   logic [31:0] regWrData, regRdData, progressAckFlags, rxFragStatus, finalAckStatus;
   logic [31:0] noticeRxFields, noticeTxFields, noticeIndFields;
   int          fails, checked, ups, notices;
   fachs_core #(.REVERT_COUNT(REV)) i_fachs_core (.*);
   fachs_peer_model i_fachs_peer_model (.*);
   // clock
   always #5 sys_clk = ~sys_clk;
   // log requested cells and count upward pulses
   always @(posedge sys_clk) begin
      if (sendCellReq === 1'b1) cellLog <= {cellLog[14:0], sendCellNum};
      if (frameUpInd === 1'b1) ups++;
      if (noticeTxReq === 1'b1) notices++;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      tick(1);
      regWr <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      regAddr <= a;
      regRd <= 1'b1;
      tick(1);
      regRd <= 1'b0;
      #1 chk("read", exp, regRdData);
   endtask
   task automatic end_of_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog, the sequence needs about 1450 cycles
   initial begin
      tick(10000);
      fails++;
      end_of_test();
   end
   // main sequence
   initial begin
      {sys_clk, regAddr, regWrData, regWr, regRd, progressAckValid, progressAckMask} = '0;
      {progressAckFlags, finalFragDone, ackRequestFlag, filterDone, rxFragStatus} = '0;
      {deferredAckReq, deferredFeedback, noticeRx, noticeRxFields, slowPeer, ackNotice} = '0;
      {cellLog, fails, checked, ups, notices} = '0;
      linkAlive = 1'b1;
      rst = 1'b1;
      tick(8);
      rst <= 1'b0;
      tick(1);
      rd(ADDR_CTRL, 32'h0000_0300);
      wr(ADDR_CTRL, 32'h0000_0700);
      rd(ADDR_CTRL, 32'h0000_0700);
      rd(8'h20, 32'h0000_0000);
      $display("registers done");
      // groups of two, fragments one to four, slow airtime
      slowPeer <= 1'b1;
      wr(ADDR_CTRL, 32'h0004_2302);
      tick(60);
      chk("cells", 32'h0000_0022, {12'h0, cellLog});
      progressAckMask <= 4'h1;
      progressAckFlags <= 32'h0000_0005;
      progressAckValid <= 1'b1;
      tick(1);
      progressAckValid <= 1'b0;
      tick(60);
      chk("cells", 32'h0000_8823, {12'h0, cellLog});
      tick(1100);
      chk("cells", 32'h0001_0463, {12'h0, cellLog});
      progressAckMask <= 4'h0;
      progressAckValid <= 1'b1;
      tick(1);
      progressAckValid <= 1'b0;
      tick(40);
      chk("cells", 32'h0001_0463, {12'h0, cellLog});
      $display("originator done");
      // immediate then deferred final ack
      wr(ADDR_CTRL, 32'h0000_0300);
      {rxFragStatus, ackRequestFlag, filterDone, finalFragDone} <= {32'h0000_001E, 3'b111};
      tick(1);
      finalFragDone <= 1'b0;
      tick(3);
      chk("status", 32'h0000_001E, finalAckStatus);
      chk("hasStatus", 32'h1, {31'h0, finalAckHasStatus});
      wr(ADDR_CTRL, 32'h0000_1300);
      finalFragDone <= 1'b1;
      tick(1);
      finalFragDone <= 1'b0;
      tick(3);
      chk("pending", 32'h1, {31'h0, finalAckPending});
      chk("upward", 32'h1, ups);
      {deferredFeedback, deferredAckReq} <= {16'hA5C3, 1'b1};
      tick(1);
      deferredAckReq <= 1'b0;
      tick(3);
      chk("feedback", 32'h0000_A5C3, {16'h0, finalAckFeedback});
      $display("final ack done");
      // switch refused, unacknowledged, acknowledged, reverted
      wr(ADDR_CHANNEL, 32'h0000_0300);
      wr(ADDR_SWITCH, 32'h0000_0712);
      tick(20);
      chk("notices", 32'h0, notices);
      wr(ADDR_CHANNEL, 32'h0000_0200);
      wr(ADDR_SWITCH, 32'hBEEF_0712);
      tick(20);
      chk("notices", 32'h1, notices);
      chk("fields", 32'h0000_0712, noticeTxFields);
      chk("channel", 32'h0, {24'h0, activeChannel});
      {ackNotice, linkAlive} <= 2'b10;
      wr(ADDR_SWITCH, 32'h0000_0734);
      tick(20);
      chk("channel", 32'h34, {24'h0, activeChannel});
      tick(REV + 30);
      chk("channel", 32'h0, {24'h0, activeChannel});
      {noticeRxFields, noticeRx} <= {32'h1234_5607, 1'b1};
      tick(1);
      noticeRx <= 1'b0;
      tick(2);
      chk("indication", 32'h1234_5607, noticeIndFields);
      $display("switch done");
      end_of_test();
   end
endmodule
